// ### ccs_sequencer.sv
// Charge phase sequencer with timers, shipping mode, pins and alerts
`timescale 1ns/1ns
`default_nettype none
module ccs_sequencer #(
  parameter int SEC_CYCLES = ccs_pkg::SEC_CYC,
  parameter int ALERT_CYCLES = ccs_pkg::ALERT_CYC,
  parameter int BLINK_CYCLES = ccs_pkg::BLINK_CYC
) (
  input wire logic mclk, // 25 MHz clock
  input wire logic srst, // Synchronous reset
  input wire logic [3:0] reg_addr, // Register byte address
  input wire logic [15:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [15:0] reg_rdata, // Read data, cycle after strobe
  input wire logic vbat_below_short, // Battery under 2.2 V
  input wire logic vbat_below_pre, // Battery under 3 V
  input wire logic vbat_below_lowv, // Battery under low-battery level
  input wire logic vbat_above_recharge, // Battery over recharge level
  input wire logic ichg_below_term, // Charge current under term level
  input wire logic input_current_limiting_flag, // Input limit active
  input wire logic thermal_regulating, // Thermal regulation active
  input wire logic charge_enable_n, // Enable pin, low enables
  input wire logic adapter_present, // Adapter attached
  input wire logic input_qualified, // All input checks pass
  input wire logic source_detect_done, // Source type detection over
  input wire logic source_identified, // Pulse: source identified
  input wire logic good_input_event, // Pulse: good input found
  input wire logic input_removed_event, // Pulse: input removed
  input wire logic input_overvoltage, // Input fault present
  input wire logic thermal_shutdown, // Thermal fault present
  output logic battery_switch, // Battery switch closed
  output logic recharge_threshold_select, // Recharge level choice
  output logic power_good_pin_n, // Power good, low active
  output logic indicator_out, // Indicator pin drive level
  output logic indicator_oe, // Indicator pin pull-down enable
  output logic alert_n // Alert pulse, low active
);

  localparam logic [31:0] SEC_LAST = 32'(SEC_CYCLES - 1);
  localparam logic [31:0] ALERT_LAST = 32'(ALERT_CYCLES - 1);
  localparam logic [31:0] BLINK_LAST = 32'(BLINK_CYCLES - 1);

  // Fast-charge limit by select field, 2 h limit below low level
  function automatic logic [16:0] safety_limit(input logic [1:0] sel,
                                                input logic low);
    logic [16:0] lim;
    case (sel)
      2'h0: lim = ccs_pkg::FAST_LIMIT_H0;
      2'h1: lim = ccs_pkg::FAST_LIMIT_H1;
      2'h2: lim = ccs_pkg::FAST_LIMIT_H2;
      default: lim = ccs_pkg::FAST_LIMIT_H3;
    endcase
    safety_limit = low ? ccs_pkg::LOWV_LIMIT_S : lim;
  endfunction

  ccs_pkg::ccs_state_t st_q, st_d, pick_st;
  logic [15:0] ctrl_q, ctrl_d;
  logic [31:0] pre_q, al_cnt_q, blink_cnt_q;
  logic [16:0] safe_q, safe_lim;
  logic [11:0] topoff_q, topoff_len_s;
  logic [1:0] topoff_len_q, fault_q, fault_live, phase;
  logic [7:0] ship_cnt_q;
  logic half_q, ship_q, alert_q, blink_q, pg_q, bsw_q, ind_oe_q;
  logic lock_q, read_seen_q, en_q, dpm_q, adapter_q;
  logic sec_tick, slow, cnt_tick, reg_active, fault_active, en_req;
  logic term_hit, term_evt, topoff_done, topoff_exp, safety_exp;
  logic charging, en_rise, adapter_rise, dpm_evt, fault_evt, any_evt;
  logic wr_ctrl, rd_fault, reg_rst_w, term_en, timer_en, half_allow;
  logic [1:0] limit_sel, ind_cfg, topoff_set;

  // Register decode and control fields
  assign wr_ctrl = reg_wr && (reg_addr == ccs_pkg::ADDR_CTRL);
  assign rd_fault = reg_rd && (reg_addr == ccs_pkg::ADDR_FAULT);
  assign reg_rst_w = wr_ctrl && reg_wdata[ccs_pkg::CTL_REG_RST];
  assign term_en = ctrl_q[ccs_pkg::CTL_TERM_EN];
  assign timer_en = ctrl_q[ccs_pkg::CTL_TIMER_EN];
  assign half_allow = ctrl_q[ccs_pkg::CTL_HALF_ALLOW];
  assign limit_sel = ctrl_q[ccs_pkg::CTL_LIMIT_LO +: 2];
  assign ind_cfg = ctrl_q[ccs_pkg::CTL_IND_LO +: 2];
  assign topoff_set = ctrl_q[ccs_pkg::CTL_TOPOFF_LO +: 2];
  assign recharge_threshold_select = ctrl_q[ccs_pkg::CTL_RECHG];

  // Register reset bit is a self-clearing action, never stored
  always_comb begin
    ctrl_d = ctrl_q;
    if (reg_rst_w) begin
      ctrl_d = ccs_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_d = reg_wdata & ~(16'h0001 << ccs_pkg::CTL_REG_RST);
    end
    if (adapter_rise) begin
      ctrl_d[ccs_pkg::CTL_SW_OFF] = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_q <= ccs_pkg::CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Charging request from config bit, pin and switch-off bit
  assign en_req = ctrl_q[ccs_pkg::CTL_CHG_CFG] && !charge_enable_n &&
                  !ctrl_q[ccs_pkg::CTL_SW_OFF];
  assign reg_active = input_current_limiting_flag || thermal_regulating;
  assign fault_active = input_overvoltage || thermal_shutdown;
  assign en_rise = en_req && !en_q;
  assign adapter_rise = adapter_present && !adapter_q;
  assign dpm_evt = input_current_limiting_flag && !dpm_q &&
                   !ctrl_q[ccs_pkg::CTL_DPM_MASK];

  // Edge history for enable, adapter and limit flag
  always_ff @(posedge mclk) begin
    if (srst) begin
      en_q <= 1'b0;
      adapter_q <= 1'b0;
      dpm_q <= 1'b0;
    end else begin
      en_q <= en_req;
      adapter_q <= adapter_present;
      dpm_q <= input_current_limiting_flag;
    end
  end

  // One-second timebase shared by every long timer
  assign sec_tick = (pre_q == SEC_LAST);
  always_ff @(posedge mclk) begin
    if (srst || sec_tick) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 32'h1;
    end
  end

  // Half rate in regulation; faults freeze both charge timers
  assign slow = reg_active && half_allow;
  assign cnt_tick = sec_tick && !fault_active && (!slow || half_q);
  always_ff @(posedge mclk) begin
    if (srst || !slow) begin
      half_q <= 1'b0;
    end else if (sec_tick) begin
      half_q <= ~half_q;
    end
  end

  // Phase choice and termination condition
  assign pick_st = vbat_below_short ? ccs_pkg::ST_SHORT :
                   vbat_below_pre ? ccs_pkg::ST_PRE :
                   ccs_pkg::ST_FAST;
  assign term_hit = vbat_above_recharge && ichg_below_term &&
                    term_en && !reg_active;
  assign charging = (st_q == ccs_pkg::ST_SHORT) ||
                    (st_q == ccs_pkg::ST_PRE) || (st_q == ccs_pkg::ST_FAST);
  assign topoff_len_s = 12'(topoff_len_q * ccs_pkg::TOPOFF_UNIT_S);
  assign topoff_done = (topoff_q >= topoff_len_s);
  assign safe_lim = safety_limit(limit_sel,
                                 vbat_below_lowv || (st_q != ccs_pkg::ST_FAST));
  assign safety_exp = charging && timer_en && (safe_q >= safe_lim);

  // Charge cycle sequence
  always_comb begin
    st_d = st_q;
    case (st_q)
      ccs_pkg::ST_OFF: begin
        if (en_req) st_d = pick_st;
      end
      ccs_pkg::ST_SHORT: begin
        if (!vbat_below_short) st_d = ccs_pkg::ST_PRE;
      end
      ccs_pkg::ST_PRE: begin
        if (!vbat_below_pre) st_d = ccs_pkg::ST_FAST;
      end
      ccs_pkg::ST_FAST: begin
        if (term_hit) begin
          st_d = (topoff_set != 2'h0) ? ccs_pkg::ST_TOPOFF :
                 ccs_pkg::ST_DONE;
        end
      end
      ccs_pkg::ST_TOPOFF: begin
        if (topoff_done) st_d = ccs_pkg::ST_DONE;
      end
      ccs_pkg::ST_DONE: begin
        if (!vbat_above_recharge) st_d = pick_st;
      end
      ccs_pkg::ST_EXPIRED: st_d = ccs_pkg::ST_EXPIRED;
      default: st_d = ccs_pkg::ST_OFF;
    endcase
    if (safety_exp) st_d = ccs_pkg::ST_EXPIRED;
    if (!en_req || reg_rst_w) st_d = ccs_pkg::ST_OFF;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_q <= ccs_pkg::ST_OFF;
    end else begin
      st_q <= st_d;
    end
  end

  assign term_evt = (st_q == ccs_pkg::ST_FAST) &&
                    ((st_d == ccs_pkg::ST_TOPOFF) ||
                     (st_d == ccs_pkg::ST_DONE));
  assign topoff_exp = (st_q == ccs_pkg::ST_TOPOFF) &&
                      (st_d == ccs_pkg::ST_DONE);

  // Safety timer: cleared outside an active cycle, saturates at limit
  always_ff @(posedge mclk) begin
    if (srst || !charging) begin
      safe_q <= '0;
    end else if (cnt_tick && (safe_q < safe_lim)) begin
      safe_q <= safe_q + 17'h1;
    end
  end

  // Top-off timer and its setting latched at termination
  always_ff @(posedge mclk) begin
    if (srst || en_rise || term_evt || reg_rst_w) begin
      topoff_q <= '0;
    end else if ((st_q == ccs_pkg::ST_TOPOFF) && cnt_tick) begin
      topoff_q <= topoff_q + 12'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      topoff_len_q <= 2'h0;
    end else if (term_evt) begin
      topoff_len_q <= topoff_set;
    end
  end

  // Shipping mode: immediate or after the shipping delay
  always_ff @(posedge mclk) begin
    if (srst || reg_rst_w || adapter_rise ||
        !ctrl_q[ccs_pkg::CTL_SW_OFF]) begin
      ship_q <= 1'b0;
      ship_cnt_q <= '0;
    end else if (!ship_q) begin
      if (!ctrl_q[ccs_pkg::CTL_SW_DLY] ||
          (ship_cnt_q == ccs_pkg::SHIP_DLY_S)) begin
        ship_q <= 1'b1;
      end else if (sec_tick) begin
        ship_cnt_q <= ship_cnt_q + 8'h1;
      end
    end
  end

  // Fault field source, priority input, thermal, timer
  assign fault_live = input_overvoltage ? ccs_pkg::FLT_INPUT :
                      thermal_shutdown ? ccs_pkg::FLT_THERMAL :
                      (st_q == ccs_pkg::ST_EXPIRED) ? ccs_pkg::FLT_TIMER :
                      ccs_pkg::FLT_NONE;
  assign fault_evt = (fault_live != ccs_pkg::FLT_NONE) && !lock_q;

  // Latched faults: a read hands back the latch, then loads present
  always_ff @(posedge mclk) begin
    if (srst) begin
      fault_q <= ccs_pkg::FLT_NONE;
      lock_q <= 1'b0;
      read_seen_q <= 1'b0;
    end else begin
      if (fault_evt) begin
        fault_q <= fault_live;
        lock_q <= 1'b1;
        read_seen_q <= 1'b0;
      end else if (rd_fault) begin
        fault_q <= fault_live;
        read_seen_q <= 1'b1;
      end else if (!lock_q) begin
        fault_q <= fault_live;
      end
      if (lock_q && read_seen_q && (fault_live == ccs_pkg::FLT_NONE)) begin
        lock_q <= 1'b0;
      end
    end
  end

  // Alert pulse, retriggered by any event; width fixed by counter
  assign any_evt = source_identified || good_input_event ||
                   input_removed_event || term_evt || topoff_exp ||
                   fault_evt || dpm_evt;
  always_ff @(posedge mclk) begin
    if (srst) begin
      alert_q <= 1'b0;
      al_cnt_q <= '0;
    end else if (any_evt) begin
      alert_q <= 1'b1;
      al_cnt_q <= ALERT_LAST;
    end else if (al_cnt_q != 32'h0) begin
      al_cnt_q <= al_cnt_q - 32'h1;
    end else begin
      alert_q <= 1'b0;
    end
  end
  assign alert_n = ~alert_q;

  // Blink timebase for the suspend indication
  always_ff @(posedge mclk) begin
    if (srst) begin
      blink_cnt_q <= '0;
      blink_q <= 1'b0;
    end else if (blink_cnt_q == BLINK_LAST) begin
      blink_cnt_q <= '0;
      blink_q <= ~blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 32'h1;
    end
  end

  // Phase field encoding
  assign phase = (st_q == ccs_pkg::ST_SHORT) ? ccs_pkg::PH_PRE :
                 (st_q == ccs_pkg::ST_PRE) ? ccs_pkg::PH_PRE :
                 (st_q == ccs_pkg::ST_FAST) ? ccs_pkg::PH_FAST :
                 ((st_q == ccs_pkg::ST_TOPOFF) ||
                  (st_q == ccs_pkg::ST_DONE)) ? ccs_pkg::PH_DONE :
                 ccs_pkg::PH_OFF;

  // Pins: switch opens in the done state, after any top-off, or in shipping mode
  always_ff @(posedge mclk) begin
    if (srst) begin
      pg_q <= 1'b0;
      bsw_q <= 1'b1;
      ind_oe_q <= 1'b0;
    end else begin
      pg_q <= input_qualified && source_detect_done;
      bsw_q <= !ship_q && (st_q != ccs_pkg::ST_DONE);
      if (ind_cfg == ccs_pkg::IND_OFF) begin
        ind_oe_q <= 1'b0;
      end else if (fault_active || (st_q == ccs_pkg::ST_EXPIRED)) begin
        ind_oe_q <= blink_q;
      end else begin
        ind_oe_q <= charging || (st_q == ccs_pkg::ST_TOPOFF);
      end
    end
  end
  assign battery_switch = bsw_q;
  assign power_good_pin_n = ~pg_q;
  assign indicator_oe = ind_oe_q;
  assign indicator_out = 1'b0; // Open drain: only ever pulls low

  // Read data in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge mclk) begin
    if (srst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        ccs_pkg::ADDR_CTRL: reg_rdata <= ctrl_q;
        ccs_pkg::ADDR_STATUS: reg_rdata <= {8'h00, bsw_q, ship_q,
          thermal_regulating, input_current_limiting_flag, pg_q,
          (st_q == ccs_pkg::ST_TOPOFF), phase};
        ccs_pkg::ADDR_FAULT: reg_rdata <= {14'h0000, fault_q};
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // Checks on the sequencing
  a_term_alert: assert property (@(posedge mclk) disable iff (srst)
    term_evt |=> alert_q && (phase == ccs_pkg::PH_DONE || !en_req))
    else $error("termination without phase 11 and alert");
  a_term_disabled: assert property (@(posedge mclk) disable iff (srst)
    (st_q == ccs_pkg::ST_FAST && !term_en) |=> st_q != ccs_pkg::ST_DONE)
    else $error("terminated with termination disabled");
  a_term_regulating: assert property (@(posedge mclk) disable iff (srst)
    (st_q == ccs_pkg::ST_FAST && reg_active) |=>
      !(st_q inside {ccs_pkg::ST_DONE, ccs_pkg::ST_TOPOFF}))
    else $error("terminated during regulation");
  a_alert_width: assert property (@(posedge mclk) disable iff (srst)
    $rose(alert_q) |-> alert_q[*8])
    else $error("alert pulse too short");
  a_timer_off: assert property (@(posedge mclk) disable iff (srst)
    (!timer_en && st_q != ccs_pkg::ST_EXPIRED) |=>
      st_q != ccs_pkg::ST_EXPIRED)
    else $error("expiry with timer disabled");
  a_ship_exit: assert property (@(posedge mclk) disable iff (srst)
    (ship_q && adapter_rise) |=> !ship_q ##1 bsw_q)
    else $error("adapter did not end shipping mode");
  a_power_good: assert property (@(posedge mclk) disable iff (srst)
    !(input_qualified && source_detect_done) |=> power_good_pin_n)
    else $error("power good without qualification");
  a_fault_reread: assert property (@(posedge mclk) disable iff (srst)
    (rd_fault && !fault_evt) |=> fault_q == $past(fault_live))
    else $error("fault read did not load present state");
  a_topoff_pause: assert property (@(posedge mclk) disable iff (srst)
    (st_q == ccs_pkg::ST_TOPOFF && fault_active && !reg_rst_w) |=>
      $stable(topoff_q))
    else $error("top-off timer ran during fault");
  a_indicator_off: assert property (@(posedge mclk) disable iff (srst)
    (ind_cfg == ccs_pkg::IND_OFF) |=> !indicator_oe)
    else $error("indicator driven while disabled");

endmodule // ccs_sequencer
`default_nettype wire

// ### ccs_pkg.sv
// Constants, register map and field layout of the charge cycle sequencer
package ccs_pkg;

  localparam int CLK_HZ = 25_000_000;
  // Timebase: one second tick, alert width, blink half period
  localparam int SEC_S = 1;
  localparam int SEC_CYC = SEC_S * CLK_HZ;
  localparam int ALERT_US = 256;
  localparam int ALERT_CYC =
    int'((64'(ALERT_US) * 64'(CLK_HZ)) / 64'hF4240);
  localparam int BLINK_HALF_MS = 500;
  localparam int BLINK_CYC =
    int'((64'(BLINK_HALF_MS) * 64'(CLK_HZ)) / 64'h3E8);

  // Safety, top-off and shipping durations in seconds
  localparam int SEC_PER_H = 3600;
  localparam logic [16:0] LOWV_LIMIT_S = 17'(2 * SEC_PER_H);
  localparam logic [16:0] FAST_LIMIT_H0 = 17'(5 * SEC_PER_H);
  localparam logic [16:0] FAST_LIMIT_H1 = 17'(10 * SEC_PER_H);
  localparam logic [16:0] FAST_LIMIT_H2 = 17'(15 * SEC_PER_H);
  localparam logic [16:0] FAST_LIMIT_H3 = 17'(20 * SEC_PER_H);
  localparam int TOPOFF_UNIT_S = 900;
  localparam logic [7:0] SHIP_DLY_S = 8'h0A;

  // Register byte addresses
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_FAULT = 4'h8;

  // Control register fields
  localparam int CTL_CHG_CFG = 0;
  localparam int CTL_TERM_EN = 1;
  localparam int CTL_TIMER_EN = 2;
  localparam int CTL_HALF_ALLOW = 3;
  localparam int CTL_SW_OFF = 4;
  localparam int CTL_SW_DLY = 5;
  localparam int CTL_REG_RST = 6;
  localparam int CTL_DPM_MASK = 7;
  localparam int CTL_LIMIT_LO = 8;
  localparam int CTL_IND_LO = 10;
  localparam int CTL_RECHG = 12;
  localparam int CTL_TOPOFF_LO = 14;
  localparam logic [15:0] CTRL_RST = 16'h010F;

  // Two-bit field codes
  localparam logic [1:0] PH_OFF = 2'h0;
  localparam logic [1:0] PH_PRE = 2'h1;
  localparam logic [1:0] PH_FAST = 2'h2;
  localparam logic [1:0] PH_DONE = 2'h3;
  localparam logic [1:0] FLT_NONE = 2'h0;
  localparam logic [1:0] FLT_INPUT = 2'h1;
  localparam logic [1:0] FLT_THERMAL = 2'h2;
  localparam logic [1:0] FLT_TIMER = 2'h3;
  localparam logic [1:0] IND_OFF = 2'h3;

  typedef enum logic [2:0] {
    ST_OFF, ST_SHORT, ST_PRE, ST_FAST, ST_TOPOFF, ST_DONE, ST_EXPIRED
  } ccs_state_t;

endpackage

// ### ccs_host_model.sv
// Host model: register bus master and alert pulse timer
`timescale 1ns/1ns
`default_nettype none
module ccs_host_model (
  input wire logic mclk, // Clock
  output logic [3:0] reg_addr, // Address
  output logic [15:0] reg_wdata, // Write data
  output logic reg_wr, // Write strobe
  output logic reg_rd, // Read strobe
  output logic rd_valid, // Read data stands now
  input wire logic alert_n, // Alert from device
  output logic alert_done, // Alert just ended
  output int alert_len // Last alert width
);
  int cnt;
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Read data belongs to the cycle after the strobe
  always @(posedge mclk) rd_valid <= reg_rd;
  // Width of each low alert pulse in cycles
  always @(posedge mclk) begin
    alert_done <= 1'b0;
    if (alert_n === 1'b0) cnt <= cnt + 1;
    else if (cnt != 0) begin
      alert_len <= cnt;
      alert_done <= 1'b1;
      cnt <= 0;
    end
  end
  // Write: strobe held for exactly one sampling edge
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d; // Stale data never looks valid
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask
endmodule // ccs_host_model
`default_nettype wire

// ### charge_cycle_sequencer_tb_top.sv
// Self-checking bench of the charge cycle sequencer
`timescale 1ns/1ns
`default_nettype none
module charge_cycle_sequencer_tb_top;
  logic mclk, srst, sh, pr, rch, itm, icl, en_n, adp, qual, sdd, ov;
  logic ev_si, ev_gi, ev_ir, thr, tsd, lowv, ind_o, blk;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, rd_valid, alert_done, alert_n;
  logic bsw, pg_n, ind_oe, rsel;
  int alert_len, err_total, checks_done;
  string nq[$];
  logic [15:0] eq[$], mq[$];
  int aq[$];
  logic [31:0] rs;
  ccs_sequencer #(.SEC_CYCLES(10), .ALERT_CYCLES(8), .BLINK_CYCLES(4)) dut (
    .mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .vbat_below_short(sh), .vbat_below_pre(pr), .vbat_below_lowv(lowv),
    .vbat_above_recharge(rch), .ichg_below_term(itm),
    .input_current_limiting_flag(icl), .thermal_regulating(thr),
    .charge_enable_n(en_n), .adapter_present(adp), .input_qualified(qual),
    .source_detect_done(sdd), .source_identified(ev_si),
    .good_input_event(ev_gi), .input_removed_event(ev_ir),
    .input_overvoltage(ov), .thermal_shutdown(tsd), .battery_switch(bsw),
    .recharge_threshold_select(rsel), .power_good_pin_n(pg_n),
    .indicator_out(ind_o), .indicator_oe(ind_oe), .alert_n(alert_n));
  ccs_host_model host (.mclk(mclk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .rd_valid(rd_valid), .alert_n(alert_n), .alert_done(alert_done),
    .alert_len(alert_len));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic cmp16(input string n, input logic [15:0] e,
                       input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmp1(input string n, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask
  // Read with expectation noted before the strobe goes out
  task automatic rd(input logic [3:0] a, input logic [15:0] e,
                    input logic [15:0] m, input string n);
    nq.push_back(n);
    eq.push_back(e);
    mq.push_back(m);
    host.rd(a);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Watcher: oldest note against each read and each alert pulse
  always @(negedge mclk) begin
    if (rd_valid === 1'b1)
      cmp16(nq.pop_front(), eq.pop_front(), reg_rdata & mq.pop_front());
    if (alert_done === 1'b1) begin
      if (aq.size() == 0) cmp16("alert_extra", 16'h0000, 16'(alert_len));
      else cmp16("alert_width", 16'(aq.pop_front()), 16'(alert_len));
    end
  end
  // Hang guard
  initial begin
    cyc(30000);
    err_total++;
    $display("[ERR] run expected end seen hang");
    wrap_up();
  end
  initial begin
    {sh, pr, rch, itm, icl, adp, qual, sdd, ov, thr, tsd, lowv} = 12'h000;
    {srst, en_n, ev_si, ev_gi, ev_ir, err_total, checks_done} =
      {2'b11, 3'h0, 64'h0};
    rs = 32'h00014A15;
    cyc(16);
    srst <= 1'b0;
    rd(ccs_pkg::ADDR_CTRL, 16'h010F, 16'hFFFF, "ctrl_reset");
    rd(4'hC, 16'h0000, 16'hFFFF, "unmapped");
    rs = xs(rs);
    lowv <= rs[1];
    host.wr(ccs_pkg::ADDR_CTRL, 16'h010F | {3'h0, rs[0], 12'h000});
    rd(ccs_pkg::ADDR_CTRL, 16'h010F | {3'h0, rs[0], 12'h000}, 16'hFFFF,
       "ctrl_back");
    cmp1("recharge_sel", rs[0], rsel);
    // Each listed event gives one full-width pulse
    for (int k = 0; k < 3; k++) begin
      aq.push_back(8);
      @(posedge mclk);
      {ev_ir, ev_gi, ev_si} <= 3'(1 << k);
      @(posedge mclk);
      {ev_ir, ev_gi, ev_si} <= 3'h0;
      cyc(20);
    end
    qual <= 1'b1;
    cyc(4);
    cmp1("pg_pin_n", 1'b1, pg_n);
    sdd <= 1'b1;
    cyc(4);
    cmp1("pg_pin_n", 1'b0, pg_n);
    rd(ccs_pkg::ADDR_STATUS, 16'h0008, 16'h0008, "pg_flag");
    {sh, pr} <= 2'b11;
    en_n <= 1'b0;
    cyc(4);
    rd(ccs_pkg::ADDR_STATUS, 16'h0001, 16'h0003, "phase_short");
    en_n <= 1'b1;
    cyc(4);
    rd(ccs_pkg::ADDR_STATUS, 16'h0000, 16'h0003, "phase_off");
    {sh, pr, en_n} <= 3'b000;
    cyc(4);
    rd(ccs_pkg::ADDR_STATUS, 16'h0002, 16'h0003, "phase_fast");
    cmp1("ind_oe", 1'b1, ind_oe);
    // Regulation holds off termination; the flag rise alerts
    aq.push_back(8);
    {rch, itm, icl} <= 3'b111;
    cyc(20);
    rd(ccs_pkg::ADDR_STATUS, 16'h0012, 16'h0013, "phase_reg");
    host.wr(ccs_pkg::ADDR_CTRL, 16'h010D);
    icl <= 1'b0;
    cyc(20);
    rd(ccs_pkg::ADDR_STATUS, 16'h0002, 16'h0003, "phase_noterm");
    // Thermal regulation also holds off termination, without an alert
    thr <= 1'b1;
    host.wr(ccs_pkg::ADDR_CTRL, 16'h410F);
    cyc(20);
    rd(ccs_pkg::ADDR_STATUS, 16'h0022, 16'h0023, "phase_thermal");
    // Termination enters one top-off unit; its length is captured then
    aq.push_back(8);
    thr <= 1'b0;
    cyc(20);
    rd(ccs_pkg::ADDR_STATUS, 16'h0007, 16'h0007, "topoff_on");
    cmp1("bat_switch", 1'b1, bsw);
    host.wr(ccs_pkg::ADDR_CTRL, 16'h010F);
    cyc(20);
    rd(ccs_pkg::ADDR_STATUS, 16'h0007, 16'h0007, "topoff_kept");
    // Faults pause top-off; a second fault while latched stays silent
    aq.push_back(8);
    ov <= 1'b1;
    cyc(16);
    blk = ind_oe;
    cyc(4);
    cmp1("ind_blink", !blk, ind_oe);
    ov <= 1'b0;
    cyc(4);
    ov <= 1'b1;
    cyc(20);
    ov <= 1'b0;
    cyc(4);
    rd(ccs_pkg::ADDR_FAULT, 16'h0001, 16'h0003, "fault_latched");
    rd(ccs_pkg::ADDR_FAULT, 16'h0000, 16'h0003, "fault_now");
    aq.push_back(8);
    tsd <= 1'b1;
    cyc(20);
    tsd <= 1'b0;
    cyc(4);
    rd(ccs_pkg::ADDR_FAULT, 16'h0002, 16'h0003, "fault_thermal");
    rd(ccs_pkg::ADDR_FAULT, 16'h0000, 16'h0003, "fault_clear");
    // Top-off runs out after one unit plus the paused time, then alerts
    aq.push_back(8);
    cyc(9000);
    rd(ccs_pkg::ADDR_STATUS, 16'h0003, 16'h0007, "phase_done");
    cmp1("bat_switch", 1'b0, bsw);
    cmp1("ind_oe", 1'b0, ind_oe);
    cmp1("ind_out", 1'b0, ind_o);
    rch <= 1'b0;
    cyc(4);
    rd(ccs_pkg::ADDR_STATUS, 16'h0002, 16'h0003, "phase_rechg");
    cmp1("bat_switch", 1'b1, bsw);
    // Shipping: at once, adapter exit, delayed, bit-clear exit
    host.wr(ccs_pkg::ADDR_CTRL, 16'h011F);
    cyc(4);
    cmp1("bat_switch", 1'b0, bsw);
    adp <= 1'b1;
    cyc(4);
    cmp1("bat_switch", 1'b1, bsw);
    host.wr(ccs_pkg::ADDR_CTRL, 16'h013F);
    cyc(50);
    cmp1("bat_switch", 1'b1, bsw);
    cyc(80);
    cmp1("bat_switch", 1'b0, bsw);
    host.wr(ccs_pkg::ADDR_CTRL, 16'h010F);
    cyc(4);
    cmp1("bat_switch", 1'b1, bsw);
    // Register reset restores control and ends shipping
    host.wr(ccs_pkg::ADDR_CTRL, 16'h011F);
    cyc(4);
    cmp1("bat_switch", 1'b0, bsw);
    host.wr(ccs_pkg::ADDR_CTRL, 16'h0040);
    cyc(4);
    cmp1("bat_switch", 1'b1, bsw);
    rd(ccs_pkg::ADDR_CTRL, 16'h010F, 16'hFFFF, "ctrl_regrst");
    cyc(20);
    cmp16("alerts_left", 16'h0000, 16'(aq.size()));
    wrap_up();
  end
endmodule // charge_cycle_sequencer_tb_top
`default_nettype wire
